// ===== shared/oddc_pkg.sv
/*
 * oddc_pkg: constants and types for the output divider / delay configuration block.
 * Assumes an 8-bit register address space with one byte per register.
 */
package oddc_pkg;

    // register count and storage width
    localparam int          NUM_REGS   = 8;
    localparam int          REG_W      = 8;
    localparam int          ADDR_W     = 8;

    // byte offsets
    localparam logic [7:0]  OUT5_DELAY_OFS         = 8'h3c;
    localparam logic [7:0]  OUT5_DRIVER_SUPPLY_OFS = 8'h3d;
    localparam logic [7:0]  OUT6_DIVIDER_HIGH_OFS  = 8'h40;
    localparam logic [7:0]  OUT6_DIVIDER_MID_OFS   = 8'h41;
    localparam logic [7:0]  OUT6_DIVIDER_LOW_OFS   = 8'h42;
    localparam logic [7:0]  OUT6_PHASE_STRENGTH_OFS = 8'h43;
    localparam logic [7:0]  OUT6_DELAY_OFS         = 8'h44;
    localparam logic [7:0]  OUT6_SUPPLY_CFG_OFS    = 8'h45;

    // storage index of each register
    localparam int          IDX_OUT5_DELAY   = 0;
    localparam int          IDX_OUT5_DRV     = 1;
    localparam int          IDX_OUT6_DIV_HI  = 2;
    localparam int          IDX_OUT6_DIV_MID = 3;
    localparam int          IDX_OUT6_DIV_LO  = 4;
    localparam int          IDX_OUT6_PHASE   = 5;
    localparam int          IDX_OUT6_DELAY   = 6;
    localparam int          IDX_OUT6_SUPPLY  = 7;

    localparam logic [NUM_REGS-1:0][7:0] REG_OFS = {
        OUT6_SUPPLY_CFG_OFS, OUT6_DELAY_OFS, OUT6_PHASE_STRENGTH_OFS, OUT6_DIVIDER_LOW_OFS,
        OUT6_DIVIDER_MID_OFS, OUT6_DIVIDER_HIGH_OFS, OUT5_DRIVER_SUPPLY_OFS, OUT5_DELAY_OFS};

    // writable bits; others read zero
    localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {
        8'h1f, 8'hff, 8'hc7, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff};

    localparam logic [7:0]  REG_RESET  = 8'h00;
    localparam logic [7:0]  RDATA_NONE = 8'h00;

    // field positions
    localparam int          DIV_W        = 20;
    localparam int          DIV_HI_MSB   = 3;
    localparam int          COARSE_MSB   = 5;
    localparam int          FINE_LSB     = 6;
    localparam int          FINE_MSB     = 7;
    localparam int          PHASE_LSB    = 6;
    localparam int          PHASE_MSB    = 7;
    localparam int          STRENGTH_MSB = 2;
    localparam int          DRV_MSB      = 2;
    localparam int          SUPPLY_LSB   = 3;
    localparam int          SUPPLY_MSB   = 4;

    // timing figures and advised drive strength
    localparam int          FINE_STEP_PS     = 30;
    localparam int          COARSE_MAX_VCO   = 63;
    localparam logic [2:0]  STRENGTH_ADVISED = 3'h7;

    typedef enum logic [2:0] {
        ODDC_DRV_LVDS        = 3'b000,
        ODDC_DRV_LVPECL_CM   = 3'b001,
        ODDC_DRV_CML         = 3'b010,
        ODDC_DRV_HCSL        = 3'b011,
        ODDC_DRV_LVDS_BOOST  = 3'b100,
        ODDC_DRV_LVPECL_NOCM = 3'b101,
        ODDC_DRV_RSVD6       = 3'b110,
        ODDC_DRV_RSVD7       = 3'b111
    } oddc_drv_std_t;

    typedef enum logic [1:0] {
        ODDC_VDD_1V8  = 2'b00,
        ODDC_VDD_2V5  = 2'b01,
        ODDC_VDD_3V3  = 2'b10,
        ODDC_VDD_RSVD = 2'b11
    } oddc_supply_t;

    // register port request
    typedef struct packed {
        logic               wr;
        logic               rd;
        logic [ADDR_W-1:0]  addr;
        logic [REG_W-1:0]   wdata;
    } oddc_req_t;

    typedef struct packed {
        logic [5:0]         coarse_delay;
        logic [1:0]         fine_delay;
        oddc_drv_std_t      driver_standard_select;
        oddc_supply_t       output_supply_select;
    } oddc_out5_cfg_t;

    typedef struct packed {
        logic [DIV_W-1:0]   output_divider;
        logic [1:0]         phase_sel;
        logic [2:0]         se_strength;
        logic [5:0]         coarse_delay;
        logic [1:0]         fine_delay;
        oddc_supply_t       output_supply_select;
        logic               positive_pin_driver;  // 0 true_clock, 1 complement_clock
        logic               negative_pin_driver;  // 0 true_clock, 1 complement_clock
    } oddc_out6_cfg_t;

endpackage

// ===== core/oddc_regs.sv
/*
 * oddc_regs: configuration registers for clock outputs five and six, with
 * decoded divider, delay, phase, driver and supply settings.
 * Assumes the register port is driven synchronously to mclk_i by the serial front end.
 */
`timescale 1ns/1ps

module oddc_regs (
    // clock and reset
    input  wire logic                       mclk_i,
    input  wire logic                       rst_i,
    // register port
    input  wire oddc_pkg::oddc_req_t        req_i,
    output logic [7:0]                      rdata_o,
    output logic                            rvalid_o,
    // decoded configuration
    output oddc_pkg::oddc_out5_cfg_t        out5_cfg_o,
    output oddc_pkg::oddc_out6_cfg_t        out6_cfg_o,
    output logic                            strength_unadvised_o
);
    import oddc_pkg::*;

    logic [REG_W-1:0]       regs_q [NUM_REGS];
    logic [NUM_REGS-1:0]    hit;
    logic [REG_W-1:0]       rd_mux;
    logic [REG_W-1:0]       rdata_q;
    logic                   rvalid_q;

    // address decode and write per entry, masked so unused bits stay zero
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            assign hit[gi] = (req_i.addr == REG_OFS[gi]);
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    regs_q[gi] <= REG_RESET;
                end else if (req_i.wr && hit[gi]) begin
                    regs_q[gi] <= req_i.wdata & REG_MASK[gi];
                end
            end
        end
    endgenerate

    // read select; an unmapped address reads zero
    always_comb begin
        rd_mux = RDATA_NONE;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (hit[i]) begin
                rd_mux = regs_q[i];
            end
        end
    end

    // read data held until the next read
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q  <= RDATA_NONE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= req_i.rd;
            if (req_i.rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign rdata_o  = rdata_q;
    assign rvalid_o = rvalid_q;

    // output five fields
    assign out5_cfg_o.coarse_delay = regs_q[IDX_OUT5_DELAY][COARSE_MSB:0];
    assign out5_cfg_o.fine_delay   = regs_q[IDX_OUT5_DELAY][FINE_MSB:FINE_LSB];
    assign out5_cfg_o.driver_standard_select =
        oddc_drv_std_t'(regs_q[IDX_OUT5_DRV][DRV_MSB:0]);
    assign out5_cfg_o.output_supply_select =
        oddc_supply_t'(regs_q[IDX_OUT5_DRV][SUPPLY_MSB:SUPPLY_LSB]);

    // output six divider: spare bits of the high byte are kept but not used
    assign out6_cfg_o.output_divider = {regs_q[IDX_OUT6_DIV_HI][DIV_HI_MSB:0],
                                        regs_q[IDX_OUT6_DIV_MID],
                                        regs_q[IDX_OUT6_DIV_LO]};
    assign out6_cfg_o.phase_sel    = regs_q[IDX_OUT6_PHASE][PHASE_MSB:PHASE_LSB];
    assign out6_cfg_o.se_strength  = regs_q[IDX_OUT6_PHASE][STRENGTH_MSB:0];
    assign out6_cfg_o.coarse_delay = regs_q[IDX_OUT6_DELAY][COARSE_MSB:0];
    assign out6_cfg_o.fine_delay   = regs_q[IDX_OUT6_DELAY][FINE_MSB:FINE_LSB];
    assign out6_cfg_o.output_supply_select =
        oddc_supply_t'(regs_q[IDX_OUT6_SUPPLY][SUPPLY_MSB:SUPPLY_LSB]);

    // pin sources: 00 true/comp, 01 true/true, 1x comp/comp
    assign out6_cfg_o.positive_pin_driver = out6_cfg_o.phase_sel[1];
    assign out6_cfg_o.negative_pin_driver = (out6_cfg_o.phase_sel != 2'b01);

    // flag only; the value is not forced since software owns the choice
    assign strength_unadvised_o = (out6_cfg_o.se_strength != STRENGTH_ADVISED);

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_write(logic [7:0] ofs);
        req_i.wr && (req_i.addr == ofs);
    endsequence

    sequence s_read_next(logic [7:0] ofs);
        ##1 (req_i.rd && !req_i.wr && (req_i.addr == ofs));
    endsequence

    a_write_read_back: assert property (
        (s_write(OUT6_PHASE_STRENGTH_OFS) ##0 s_read_next(OUT6_PHASE_STRENGTH_OFS))
        |=> rvalid_o && (rdata_o == ($past(req_i.wdata, 2) & REG_MASK[IDX_OUT6_PHASE])))
        else $error("read back differs from last masked write");

    a_unmapped_zero: assert property (
        (req_i.rd && (req_i.addr == 8'h3e)) |=> rvalid_o && (rdata_o == 8'h00))
        else $error("unmapped read not zero");

    a_divider_assembly: assert property (
        s_write(OUT6_DIVIDER_HIGH_OFS) |=> out6_cfg_o.output_divider[19:16] == $past(req_i.wdata[3:0]))
        else $error("divider high nibble not taken");

    a_coarse_delay_set: assert property (
        s_write(OUT6_DELAY_OFS) |=> out6_cfg_o.coarse_delay == $past(req_i.wdata[5:0]))
        else $error("coarse delay not taken from bits 5:0");

    a_fine_delay_set: assert property (
        s_write(OUT5_DELAY_OFS) |=> out5_cfg_o.fine_delay == $past(req_i.wdata[7:6]))
        else $error("fine delay not taken from bits 7:6");

    a_phase_pin_map: assert property (
        s_write(OUT6_PHASE_STRENGTH_OFS) |=>
            (out6_cfg_o.positive_pin_driver == $past(req_i.wdata[7])) &&
            (out6_cfg_o.negative_pin_driver == ($past(req_i.wdata[7:6]) != 2'b01)))
        else $error("phase select pin mapping wrong");

    a_driver_standard: assert property (
        s_write(OUT5_DRIVER_SUPPLY_OFS) |=> out5_cfg_o.driver_standard_select == $past(req_i.wdata[2:0]))
        else $error("driver standard not taken from bits 2:0");

    a_supply_select: assert property (
        s_write(OUT6_SUPPLY_CFG_OFS) |=> out6_cfg_o.output_supply_select == $past(req_i.wdata[4:3]))
        else $error("supply select not taken from bits 4:3");

    a_held_no_write: assert property (
        !req_i.wr |=> $stable(out6_cfg_o.output_divider) && $stable(out5_cfg_o))
        else $error("configuration changed without a write");

    sequence s_read(logic [7:0] ofs);
        req_i.rd && (req_i.addr == ofs);
    endsequence

    // every read strobe gets its answer one edge later
    a_read_answer_next: assert property (
        req_i.rd |=> rvalid_o)
        else $error("read not answered on the next edge");

    // no answer without a read strobe
    a_no_stray_answer: assert property (
        !req_i.rd |=> !rvalid_o)
        else $error("read answer without a read");

    // read data stands until the next read
    a_rdata_held: assert property (
        !req_i.rd |=> $stable(rdata_o))
        else $error("read data changed without a read");

    // output five coarse delay
    a_out5_coarse_set: assert property (
        s_write(OUT5_DELAY_OFS) |=> out5_cfg_o.coarse_delay == $past(req_i.wdata[5:0]))
        else $error("output five coarse delay not taken");

    // output six fine delay
    a_out6_fine_set: assert property (
        s_write(OUT6_DELAY_OFS) |=> out6_cfg_o.fine_delay == $past(req_i.wdata[7:6]))
        else $error("output six fine delay not taken");

    // divider middle byte
    a_div_mid_set: assert property (
        s_write(OUT6_DIVIDER_MID_OFS) |=> out6_cfg_o.output_divider[15:8] == $past(req_i.wdata))
        else $error("divider middle byte not taken");

    // divider low byte
    a_div_low_set: assert property (
        s_write(OUT6_DIVIDER_LOW_OFS) |=> out6_cfg_o.output_divider[7:0] == $past(req_i.wdata))
        else $error("divider low byte not taken");

    // no atomic update: a high byte write leaves the rest alone
    a_div_high_alone: assert property (
        s_write(OUT6_DIVIDER_HIGH_OFS) |=> $stable(out6_cfg_o.output_divider[15:0]))
        else $error("high byte write disturbed other divider bits");

    // a middle byte write leaves the high nibble alone
    a_div_mid_alone: assert property (
        s_write(OUT6_DIVIDER_MID_OFS) |=> $stable(out6_cfg_o.output_divider[19:16]))
        else $error("middle byte write disturbed the high nibble");

    // a low byte write leaves the rest alone
    a_div_low_alone: assert property (
        s_write(OUT6_DIVIDER_LOW_OFS) |=> $stable(out6_cfg_o.output_divider[19:8]))
        else $error("low byte write disturbed upper divider bits");

    // output five supply field
    a_out5_supply_set: assert property (
        s_write(OUT5_DRIVER_SUPPLY_OFS) |=> out5_cfg_o.output_supply_select == $past(req_i.wdata[4:3]))
        else $error("output five supply not taken from bits 4:3");

    // output six supply write must not touch output five
    a_out6_supply_alone: assert property (
        s_write(OUT6_SUPPLY_CFG_OFS) |=> $stable(out5_cfg_o))
        else $error("output six supply write disturbed output five");

    // drive strength stored as written
    a_strength_set: assert property (
        s_write(OUT6_PHASE_STRENGTH_OFS) |=> out6_cfg_o.se_strength == $past(req_i.wdata[2:0]))
        else $error("drive strength not taken from bits 2:0");

    // flag follows the written strength, never forced
    a_strength_flag: assert property (
        s_write(OUT6_PHASE_STRENGTH_OFS) |=> strength_unadvised_o == ($past(req_i.wdata[2:0]) != STRENGTH_ADVISED))
        else $error("strength flag wrong after write");

    // phase select stored as written
    a_phase_sel_set: assert property (
        s_write(OUT6_PHASE_STRENGTH_OFS) |=> out6_cfg_o.phase_sel == $past(req_i.wdata[7:6]))
        else $error("phase select not taken from bits 7:6");

    // code 00: true on positive, complement on negative
    a_pins_code0: assert property (
        (out6_cfg_o.phase_sel == 2'b00) |-> !out6_cfg_o.positive_pin_driver && out6_cfg_o.negative_pin_driver)
        else $error("phase code 00 pin map wrong");

    // code 01: true on both pins
    a_pins_code1: assert property (
        (out6_cfg_o.phase_sel == 2'b01) |-> !out6_cfg_o.positive_pin_driver && !out6_cfg_o.negative_pin_driver)
        else $error("phase code 01 pin map wrong");

    // codes 10 and 11: complement on both pins
    a_pins_code_hi: assert property (
        out6_cfg_o.phase_sel[1] |-> out6_cfg_o.positive_pin_driver && out6_cfg_o.negative_pin_driver)
        else $error("phase code 1x pin map wrong");

    // unmapped writes leave every field alone
    a_unmapped_dropped: assert property (
        (req_i.wr && (hit == '0)) |=> $stable(out5_cfg_o) && $stable(out6_cfg_o))
        else $error("unmapped write changed a field");

    // a plain read leaves every field alone
    a_read_keeps_cfg: assert property (
        (req_i.rd && !req_i.wr) |=> $stable(out5_cfg_o) && $stable(out6_cfg_o))
        else $error("read changed a field");

    // read and write in one cycle: the read sees the old byte
    a_same_cycle_old: assert property (
        (req_i.wr && s_read(OUT6_DIVIDER_MID_OFS)) |=> rdata_o == $past(out6_cfg_o.output_divider[15:8]))
        else $error("same-cycle read did not return the old byte");

    // unused driver byte bits read zero
    a_out5_spare_zero: assert property (
        s_read(OUT5_DRIVER_SUPPLY_OFS) |=> rdata_o[7:5] == 3'h0)
        else $error("output five spare bits not zero");

    // unused supply byte bits read zero
    a_out6_spare_zero: assert property (
        s_read(OUT6_SUPPLY_CFG_OFS) |=> rdata_o[7:5] == 3'h0)
        else $error("output six supply spare bits not zero");

    // bits between phase and strength read zero
    a_phase_spare_zero: assert property (
        s_read(OUT6_PHASE_STRENGTH_OFS) |=> rdata_o[5:3] == 3'h0)
        else $error("phase byte spare bits not zero");

    // high divider byte reads back its nibble
    a_div_high_readback: assert property (
        s_read(OUT6_DIVIDER_HIGH_OFS) |=> rdata_o[3:0] == $past(out6_cfg_o.output_divider[19:16]))
        else $error("high divider nibble read back wrong");

    // output six delay byte reads back its fields
    a_out6_delay_readback: assert property (
        s_read(OUT6_DELAY_OFS) |=> rdata_o == $past({out6_cfg_o.fine_delay, out6_cfg_o.coarse_delay}))
        else $error("output six delay read back wrong");

    // output five delay byte reads back its fields
    a_out5_delay_readback: assert property (
        s_read(OUT5_DELAY_OFS) |=> rdata_o == $past({out5_cfg_o.fine_delay, out5_cfg_o.coarse_delay}))
        else $error("output five delay read back wrong");

    // middle divider byte read back
    a_div_mid_readback: assert property (
        s_read(OUT6_DIVIDER_MID_OFS) |=> rdata_o == $past(out6_cfg_o.output_divider[15:8]))
        else $error("middle divider byte read back wrong");

    // low divider byte read back
    a_div_low_readback: assert property (
        s_read(OUT6_DIVIDER_LOW_OFS) |=> rdata_o == $past(out6_cfg_o.output_divider[7:0]))
        else $error("low divider byte read back wrong");

    // supply field read back
    a_supply_readback: assert property (
        s_read(OUT6_SUPPLY_CFG_OFS) |=> rdata_o[4:3] == $past(out6_cfg_o.output_supply_select))
        else $error("output six supply read back wrong");

endmodule

// ===== verification/oddc_regs_bench.sv
/*
 * oddc_regs_bench: self-checking bench for the output five/six config registers.
 * Assumes oddc_pkg is compiled first; reads are checked by a queue-fed monitor.
 */
`timescale 1ns/1ps

module oddc_regs_bench;
    import oddc_pkg::*;

    logic            mclk_i = 1'b0;
    logic            rst_i  = 1'b1;
    oddc_req_t       req_i  = '0;
    logic [7:0]      rdata_o;
    logic            rvalid_o;
    oddc_out5_cfg_t  out5_cfg_o;
    oddc_out6_cfg_t  out6_cfg_o;
    logic            strength_unadvised_o;
    int              err_count = 0;
    int              cmp_count = 0;
    logic [7:0]      exp_q[$];
    logic [31:0]     r;

    oddc_regs dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .out5_cfg_o(out5_cfg_o), .out6_cfg_o(out6_cfg_o), .strength_unadvised_o(strength_unadvised_o));

    // 40 MHz clock
    always #12.5 mclk_i = ~mclk_i;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one request cycle, then idle; ends mid-cycle so outputs have settled
    task automatic access(input logic w, input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        req_i <= '{wr: w, rd: rd, addr: a, wdata: d};
        @(posedge mclk_i);
        req_i <= '0;
        @(negedge mclk_i);
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        access(1'b0, 1'b1, a, 8'h00);
    endtask

    // bounded wait for all outstanding reads to answer
    task automatic drain();
        for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge mclk_i);
        chk(exp_q.size(), 0);
        if (exp_q.size() != 0) report_and_stop();
    endtask

    task automatic do_reset();
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
    endtask

    // monitor: each read answer takes the oldest expectation
    always @(posedge mclk_i) begin
        if (rvalid_o === 1'b1) begin
            if (exp_q.size() != 0) chk(rdata_o, exp_q.pop_front());
            else chk(1, 0);
        end
    end

    // hang guard, counted as a mismatch
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_count++;
        report_and_stop();
    end

    initial begin
        r = $urandom(32'hc34b);
        do_reset();
        // reset values, and pins follow phase code 00
        for (int i = 0; i < NUM_REGS; i++) rd_exp(REG_OFS[i], 8'h00);
        chk(strength_unadvised_o, 1);
        chk({out6_cfg_o.positive_pin_driver, out6_cfg_o.negative_pin_driver}, 2'b01);
        drain();
        $display("test reset values done");
        // random fill, readback with unused bits reading zero, then reset again
        for (int i = 0; i < NUM_REGS; i++) begin
            r = $urandom();
            access(1'b1, 1'b0, REG_OFS[i], r[7:0]);
            rd_exp(REG_OFS[i], r[7:0] & REG_MASK[i]);
        end
        access(1'b1, 1'b0, 8'h3e, 8'ha5); // unmapped write is dropped
        rd_exp(8'h3e, 8'h00);
        drain();
        do_reset();
        for (int i = 0; i < NUM_REGS; i++) rd_exp(REG_OFS[i], 8'h00);
        drain();
        $display("test readback done");
        // divider assembled from three bytes; spare nibble kept
        r = $urandom();
        access(1'b1, 1'b0, OUT6_DIVIDER_HIGH_OFS, r[31:24]);
        access(1'b1, 1'b0, OUT6_DIVIDER_MID_OFS, r[15:8]);
        access(1'b1, 1'b0, OUT6_DIVIDER_LOW_OFS, r[7:0]);
        chk(out6_cfg_o.output_divider, {r[27:24], r[15:8], r[7:0]});
        rd_exp(OUT6_DIVIDER_HIGH_OFS, r[31:24]);
        exp_q.push_back(r[15:8]); // same-cycle read sees the old byte
        access(1'b1, 1'b1, OUT6_DIVIDER_MID_OFS, 8'h5a);
        chk(out6_cfg_o.output_divider, {r[27:24], 8'h5a, r[7:0]});
        drain();
        $display("test divider done");
        // coarse and fine delay, both outputs, up to the 63 boundary
        for (int f = 0; f < 4; f++) begin
            access(1'b1, 1'b0, OUT5_DELAY_OFS, {f[1:0], 6'(f * 21)});
            access(1'b1, 1'b0, OUT6_DELAY_OFS, {~f[1:0], 6'(63 - f * 21)});
            chk({out5_cfg_o.fine_delay, out5_cfg_o.coarse_delay}, {f[1:0], 6'(f * 21)});
            chk({out6_cfg_o.fine_delay, out6_cfg_o.coarse_delay}, {~f[1:0], 6'(63 - f * 21)});
        end
        $display("test delay done");
        // every phase code with advised strength, then an unadvised strength
        for (int p = 0; p < 4; p++) begin
            access(1'b1, 1'b0, OUT6_PHASE_STRENGTH_OFS, {p[1:0], 3'h0, STRENGTH_ADVISED});
            chk(out6_cfg_o.phase_sel, p);
            chk({out6_cfg_o.positive_pin_driver, out6_cfg_o.negative_pin_driver}, {p[1], p != 1});
            chk(strength_unadvised_o, 0);
            chk(out6_cfg_o.se_strength, STRENGTH_ADVISED);
        end
        access(1'b1, 1'b0, OUT6_PHASE_STRENGTH_OFS, 8'h03);
        chk(strength_unadvised_o, 1);
        // write then read on the very next edge; read sees the masked write
        @(posedge mclk_i);
        req_i <= '{wr: 1'b1, rd: 1'b0, addr: OUT6_PHASE_STRENGTH_OFS, wdata: 8'hff};
        exp_q.push_back(8'hff & REG_MASK[IDX_OUT6_PHASE]);
        @(posedge mclk_i);
        req_i <= '{wr: 1'b0, rd: 1'b1, addr: OUT6_PHASE_STRENGTH_OFS, wdata: 8'h00};
        @(posedge mclk_i);
        req_i <= '0;
        drain();
        $display("test phase done");
        // every driver standard against every supply code
        for (int d = 0; d < 8; d++) begin
            for (int s = 0; s < 4; s++) begin
                access(1'b1, 1'b0, OUT5_DRIVER_SUPPLY_OFS, {3'h0, s[1:0], d[2:0]});
                access(1'b1, 1'b0, OUT6_SUPPLY_CFG_OFS, {3'h0, s[1:0], 3'h0});
                chk(out5_cfg_o.driver_standard_select, d);
                chk(out5_cfg_o.output_supply_select, s);
                chk(out6_cfg_o.output_supply_select, s);
            end
        end
        $display("test driver supply done");
        report_and_stop();
    end

endmodule
